// >>> status_fault_pkg.sv
// Package with register map, field positions, codes and timing of the status and fault block.
package status_fault_pkg;

  // Serial frame: write flag, 7-bit address, 16-bit data, odd parity bit.
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned FRAME_BITS = 25;
  localparam int unsigned FR_RW = 24;
  localparam int unsigned FR_ADDR_MSB = 23;
  localparam int unsigned FR_ADDR_LSB = 17;
  localparam int unsigned FR_DATA_MSB = 16;
  localparam int unsigned FR_DATA_LSB = 1;
  localparam logic [4:0] CNT_ADDR_DONE = 5'h08;
  localparam logic [4:0] CNT_DATA_END = 5'h18;
  localparam logic [4:0] CNT_FRAME = 5'h19;

  // Register offsets.
  localparam logic [6:0] REG_REVISION = 7'h00;
  localparam logic [6:0] REG_STATUS_SET = 7'h01;
  localparam logic [6:0] REG_STATUS_CLEAR = 7'h02;
  localparam logic [6:0] REG_GENERAL_ONE = 7'h05;
  localparam logic [6:0] REG_CONV_STATUS = 7'h0d;
  localparam logic [6:0] REG_CONV_CLEAR = 7'h0e;
  localparam logic [6:0] REG_SUPPLY_FAULT = 7'h38;

  // Sticky status bit positions.
  localparam int unsigned SB_ANY_FAULT = 15;
  localparam int unsigned SB_PW_LIMIT = 14;
  localparam int unsigned SB_RAIL_INIT = 13;
  localparam int unsigned SB_PARITY = 12;
  localparam int unsigned SB_CONV = 11;
  localparam int unsigned SB_CKSUM_LSB = 8;
  localparam int unsigned SB_WATCHDOG_TWO = 7;
  localparam int unsigned SB_WATCHDOG_ONE = 6;
  localparam int unsigned SB_STATE_CHG = 5;
  localparam int unsigned SB_BRIGHT = 4;
  localparam int unsigned SB_RAIL_FAULT = 3;
  localparam int unsigned SB_TEMP_WARN = 2;
  localparam int unsigned SB_TEMP_ERR = 1;
  localparam int unsigned SB_SYS_OFF = 0;

  // General status 1 and fault register fields.
  localparam int unsigned GS_RATIO_LSB = 12;
  localparam int unsigned GS_CAUSE_LSB = 5;
  localparam int unsigned FLT_RAIL_MSB = 15;
  localparam int unsigned FLT_RAIL_LSB = 13;
  localparam int unsigned FLT_MAIN = 12;
  localparam int unsigned FLT_LOGIC = 10;
  localparam logic [15:0] FAULT_USED_MASK = 16'hF7FF;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam int unsigned CONV_W = 8;

  // Root cause of the last pass through the off state.
  localparam logic [2:0] CAUSE_POWER_ON = 3'h0;
  localparam logic [2:0] CAUSE_SYS_ON_LOW = 3'h1;
  localparam logic [2:0] CAUSE_WATCHDOG_ONE = 3'h2;
  localparam logic [2:0] CAUSE_WATCHDOG_TWO = 3'h3;
  localparam logic [2:0] CAUSE_OVER_TEMP = 3'h4;
  localparam logic [2:0] CAUSE_SW_CYCLE = 3'h5;

  // Reported top-level state codes.
  localparam logic [4:0] TOP_SHUTDOWN = 5'h00;
  localparam logic [4:0] TOP_OFF = 5'h02;
  localparam logic [4:0] TOP_STANDBY = 5'h08;
  localparam logic [4:0] TOP_DISPLAY = 5'h0C;
  localparam logic [4:0] TOP_PARK_INIT = 5'h0E;
  localparam logic [4:0] TOP_RAILS_OFF = 5'h0F;

  // Parking timing, rounded up to whole clock cycles.
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned PARK_COUNTDOWN_NS = 2000;
  localparam int unsigned PARK_DISCHARGE_NS = 1000;
  localparam logic [7:0] PARK_COUNT_LOAD = 8'((PARK_COUNTDOWN_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] DISCHARGE_LOAD = 8'((PARK_DISCHARGE_NS * CLK_MHZ + 999) / 1000);

  // Clock ratio monitor: 16-cycle window, count scaled by 11/32 so 30 MHz reads 8.
  localparam int unsigned GRAY_W = 6;
  localparam logic [3:0] RATIO_WINDOW_LAST = 4'hF;
  localparam logic [9:0] RATIO_MUL = 10'h00B;
  localparam int unsigned RATIO_SHIFT = 5;
  localparam logic [3:0] RATIO_MAX = 4'hF;

  typedef enum logic [2:0] {
    s_off,
    s_standby,
    s_display,
    s_park_count,
    s_park_discharge,
    s_shutdown
  } top_state_t;

  function automatic logic [GRAY_W-1:0] gray_to_bin(input logic [GRAY_W-1:0] g);
    logic [GRAY_W-1:0] b;
    b = g;
    for (int i = GRAY_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

endpackage

// >>> system_status_fault_regs.sv
// Top state machine, status and fault registers with two serial register ports.
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for a group of asynchronous levels.
module level_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  typedef struct packed {logic [W-1:0] meta; logic [W-1:0] sync;} sync_reg_t;
  sync_reg_t q, d;

  // The first stage feeds only the second stage.
  always_comb begin
    d.meta = async_i;
    d.sync = q.meta;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_o = q.sync;
endmodule // level_sync

// Free-running gray counter on the sequencer clock, read safely from the core clock.
module seq_gray_counter
  import status_fault_pkg::*;
(
  input wire logic sequencer_clock_i,
  input wire logic arst_n_i,
  output logic [GRAY_W-1:0] gray_o
);
  typedef struct packed {logic [GRAY_W-1:0] bin; logic [GRAY_W-1:0] gray;} cnt_reg_t;
  cnt_reg_t q, d;

  // Only one bit of the gray value moves per edge, so a sampled value is never torn.
  always_comb begin
    d.bin = q.bin + GRAY_W'(1);
    d.gray = d.bin ^ (d.bin >> 1);
  end

  always_ff @(posedge sequencer_clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign gray_o = q.gray;
endmodule // seq_gray_counter

// Oversampled serial register port; pins arrive already synchronised.
module serial_reg_port
  import status_fault_pkg::*;
#(
  parameter bit WRITABLE = 1'b1
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  input wire logic [DATA_W-1:0] rd_data_i,
  output logic [ADDR_W-1:0] rd_addr_o,
  output logic miso_o,
  output logic wr_o,
  output logic [ADDR_W-1:0] wr_addr_o,
  output logic [DATA_W-1:0] wr_data_o,
  output logic parity_err_o
);
  typedef struct packed {
    logic cs_prev;
    logic sck_prev;
    logic [4:0] cnt;
    logic [FRAME_BITS-1:0] sh;
    logic [DATA_W-1:0] out;
    logic miso;
    logic wr;
    logic perr;
    logic [ADDR_W-1:0] waddr;
    logic [DATA_W-1:0] wdata;
  } port_reg_t;
  port_reg_t q, d;

  // Frames are checked at the rising chip select; a frame of any other length is dropped.
  always_comb begin
    d = q;
    d.wr = 1'b0;
    d.perr = 1'b0;
    d.cs_prev = cs_n_i;
    d.sck_prev = sck_i;
    if (cs_n_i) begin
      d.cnt = '0;
      d.miso = 1'b0;
      if (!q.cs_prev && q.cnt == CNT_FRAME) begin
        if (^q.sh) begin
          d.wr = WRITABLE && q.sh[FR_RW];
          d.waddr = q.sh[FR_ADDR_MSB:FR_ADDR_LSB];
          d.wdata = q.sh[FR_DATA_MSB:FR_DATA_LSB];
        end else begin
          d.perr = 1'b1;
        end
      end
    end else if (sck_i && !q.sck_prev) begin
      d.sh = {q.sh[FRAME_BITS-2:0], mosi_i};
      if (q.cnt <= CNT_FRAME) begin
        d.cnt = q.cnt + 5'h01;
      end
    end else if (!sck_i && q.sck_prev) begin
      if (q.cnt == CNT_ADDR_DONE) begin
        d.miso = rd_data_i[DATA_W-1];
        d.out = {rd_data_i[DATA_W-2:0], 1'b0};
      end else if (q.cnt > CNT_ADDR_DONE && q.cnt < CNT_DATA_END) begin
        d.miso = q.out[DATA_W-1];
        d.out = {q.out[DATA_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '{cs_prev: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  // The address is complete in the low shift bits once the eighth bit is in.
  assign rd_addr_o = q.sh[ADDR_W-1:0];
  assign miso_o = q.miso;
  assign wr_o = q.wr;
  assign wr_addr_o = q.waddr;
  assign wr_data_o = q.wdata;
  assign parity_err_o = q.perr;
endmodule // serial_reg_port

// Status and fault register bank with the top-level system state machine.
module system_status_fault_regs
  import status_fault_pkg::*;
#(
  parameter logic [7:0] CHIP_REVISION = 8'h21 // Arbitrary value.
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic sequencer_clock_i,
  input wire logic system_on_request_i,
  input wire logic die_temp_warn_i,
  input wire logic die_temp_error_i,
  input wire logic [DATA_W-1:0] supply_fault_i,
  input wire logic display_request_i,
  input wire logic park_request_i,
  input wire logic power_cycle_request_i,
  input wire logic watchdog_one_error_i,
  input wire logic watchdog_two_error_i,
  input wire logic pulse_width_limit_i,
  input wire logic rail_init_timeout_i,
  input wire logic [2:0] checksum_error_i,
  input wire logic over_bright_i,
  input wire logic [CONV_W-1:0] converter_error_i,
  input wire logic primary_serial_port_sck_i,
  input wire logic primary_serial_port_cs_n_i,
  input wire logic primary_serial_port_mosi_i,
  output logic primary_serial_port_miso_o,
  input wire logic secondary_serial_port_sck_i,
  input wire logic secondary_serial_port_cs_n_i,
  input wire logic secondary_serial_port_mosi_i,
  output logic secondary_serial_port_miso_o,
  output logic mirror_park_n_o,
  output logic supplies_enable_o,
  output logic mirror_regulator_enable_o,
  output logic activity_enable_o
);
  localparam int unsigned PIN_W = 3 + DATA_W + 6;

  typedef struct packed {
    top_state_t state;
    logic [7:0] timer;
    logic [2:0] cause;
    logic park_n;
    logic supplies;
    logic regulators;
    logic activity;
    logic [DATA_W-1:0] sticky;
    logic [CONV_W-1:0] conv;
    logic [DATA_W-1:0] fault;
    logic [3:0] win;
    logic [GRAY_W-1:0] snap;
    logic [3:0] ratio;
  } top_reg_t;
  top_reg_t r_q, r_d;

  logic [PIN_W-1:0] pins_s;
  logic sys_on, temp_warn, temp_err;
  logic [DATA_W-1:0] fault_raw;
  logic p_sck, p_cs_n, p_mosi, s_sck, s_cs_n, s_mosi;
  logic [GRAY_W-1:0] seq_gray, seq_gray_s, seq_bin, win_diff;
  logic [9:0] ratio_scaled;
  logic [ADDR_W-1:0] p_rd_addr, s_rd_addr, p_wr_addr;
  logic [DATA_W-1:0] p_rd_data, s_rd_data, p_wr_data, status_rd, gs_rd, hw_set;
  logic p_wr, p_perr, park_event, any_fault;
  logic [4:0] top_code;

  // The system-on, temperature and supply-fault pins and both serial ports cross two flops before the logic looks at them.
  level_sync #(.W(PIN_W)) u_pin_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .async_i({system_on_request_i, die_temp_warn_i, die_temp_error_i, supply_fault_i,
              primary_serial_port_sck_i, primary_serial_port_cs_n_i, primary_serial_port_mosi_i,
              secondary_serial_port_sck_i, secondary_serial_port_cs_n_i,
              secondary_serial_port_mosi_i}),
    .sync_o(pins_s)
  );
  assign {sys_on, temp_warn, temp_err, fault_raw, p_sck, p_cs_n, p_mosi, s_sck, s_cs_n, s_mosi} =
      pins_s;

  // Sequencer clock domain and the gray-coded crossing of its edge count.
  seq_gray_counter u_seq_cnt (
    .sequencer_clock_i(sequencer_clock_i),
    .arst_n_i(arst_n_i),
    .gray_o(seq_gray)
  );
  level_sync #(.W(GRAY_W)) u_gray_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .async_i(seq_gray),
    .sync_o(seq_gray_s)
  );
  assign seq_bin = gray_to_bin(seq_gray_s);
  assign win_diff = seq_bin - r_q.snap;
  assign ratio_scaled = 10'({4'h0, win_diff} * RATIO_MUL) >> RATIO_SHIFT;

  // Register ports: the primary one writes, the secondary one only reads.
  serial_reg_port #(.WRITABLE(1'b1)) u_primary (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .sck_i(p_sck),
    .cs_n_i(p_cs_n),
    .mosi_i(p_mosi),
    .rd_data_i(p_rd_data),
    .rd_addr_o(p_rd_addr),
    .miso_o(primary_serial_port_miso_o),
    .wr_o(p_wr),
    .wr_addr_o(p_wr_addr),
    .wr_data_o(p_wr_data),
    .parity_err_o(p_perr)
  );
  serial_reg_port #(.WRITABLE(1'b0)) u_secondary (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .sck_i(s_sck),
    .cs_n_i(s_cs_n),
    .mosi_i(s_mosi),
    .rd_data_i(s_rd_data),
    .rd_addr_o(s_rd_addr),
    .miso_o(secondary_serial_port_miso_o),
    .wr_o(),
    .wr_addr_o(),
    .wr_data_o(),
    .parity_err_o()
  );

  // Read view of status and general status, with live summary bits.
  always_comb begin
    any_fault = |r_q.fault;
    status_rd = r_q.sticky;
    status_rd[SB_ANY_FAULT] = r_q.sticky[SB_ANY_FAULT] | any_fault;
    status_rd[SB_CONV] = r_q.sticky[SB_CONV] | (|r_q.conv);
    status_rd[SB_SYS_OFF] = r_q.sticky[SB_SYS_OFF] | !sys_on;
    case (r_q.state)
      s_off: top_code = TOP_OFF;
      s_standby: top_code = TOP_STANDBY;
      s_display: top_code = TOP_DISPLAY;
      s_park_count: top_code = TOP_PARK_INIT;
      s_park_discharge: top_code = TOP_RAILS_OFF;
      default: top_code = TOP_SHUTDOWN;
    endcase
    gs_rd = '0;
    gs_rd[GS_RATIO_LSB+:4] = r_q.ratio;
    gs_rd[GS_CAUSE_LSB+:3] = r_q.cause;
    gs_rd[4:0] = top_code;
  end

  // Address decode shared by both ports; unmapped offsets read zero.
  function automatic logic [DATA_W-1:0] read_mux(input logic [ADDR_W-1:0] a,
                                                  input logic [DATA_W-1:0] st,
                                                  input logic [DATA_W-1:0] gs,
                                                  input logic [CONV_W-1:0] cv,
                                                  input logic [DATA_W-1:0] ft);
    case (a)
      REG_REVISION: read_mux = {8'h00, CHIP_REVISION};
      REG_STATUS_SET: read_mux = st;
      REG_GENERAL_ONE: read_mux = gs;
      REG_CONV_STATUS: read_mux = {8'h00, cv};
      REG_SUPPLY_FAULT: read_mux = ft;
      default: read_mux = '0;
    endcase
  endfunction
  assign p_rd_data = read_mux(p_rd_addr, status_rd, gs_rd, r_q.conv, r_q.fault);
  assign s_rd_data = read_mux(s_rd_addr, status_rd, gs_rd, r_q.conv, r_q.fault);

  // Over-temperature is part of the park condition and no mask can remove it.
  assign park_event = !sys_on || temp_err || park_request_i || power_cycle_request_i ||
                      any_fault || watchdog_one_error_i || watchdog_two_error_i;

  // State machine, sticky flags and ratio window, all in one next-state process.
  always_comb begin
    r_d = r_q;
    case (r_q.state)
      s_off: begin
        if (sys_on && !temp_warn && !r_q.fault[FLT_MAIN] && !r_q.fault[FLT_LOGIC]) begin
          r_d.state = s_standby;
        end
      end
      s_standby: begin
        if (temp_err) begin
          r_d.state = s_shutdown;
        end else if (!sys_on) begin
          r_d.state = s_off;
          r_d.cause = CAUSE_SYS_ON_LOW;
        end else if (power_cycle_request_i) begin
          r_d.state = s_off;
          r_d.cause = CAUSE_SW_CYCLE;
        end else if (watchdog_one_error_i) begin
          r_d.state = s_off;
          r_d.cause = CAUSE_WATCHDOG_ONE;
        end else if (watchdog_two_error_i) begin
          r_d.state = s_off;
          r_d.cause = CAUSE_WATCHDOG_TWO;
        end else if (any_fault) begin
          r_d.state = s_off;
        end else if (display_request_i) begin
          r_d.state = s_display;
        end
      end
      s_display: begin
        if (park_event) begin
          r_d.state = s_park_count;
          r_d.timer = PARK_COUNT_LOAD;
        end
      end
      s_park_count: begin
        if (r_q.timer == 8'h00) begin
          r_d.state = s_park_discharge;
          r_d.timer = DISCHARGE_LOAD;
        end else begin
          r_d.timer = r_q.timer - 8'h01;
        end
      end
      s_park_discharge: begin
        if (r_q.timer == 8'h00) begin
          r_d.state = s_standby;
        end else begin
          r_d.timer = r_q.timer - 8'h01;
        end
      end
      s_shutdown: begin
        if (!sys_on) begin
          r_d.state = s_off;
          r_d.cause = CAUSE_OVER_TEMP;
        end
      end
      default: r_d.state = s_off;
    endcase
    // Outputs follow the next state so they line up with the state register.
    r_d.park_n = !(r_d.state == s_park_count || r_d.state == s_park_discharge);
    r_d.supplies = !(r_d.state == s_off || r_d.state == s_shutdown);
    r_d.activity = r_d.state != s_shutdown;
    r_d.regulators = r_d.state == s_display || r_d.state == s_park_count;

    // Hardware events; a set in the same cycle as a clear wins.
    hw_set = '0;
    hw_set[SB_PW_LIMIT] = pulse_width_limit_i;
    hw_set[SB_RAIL_INIT] = rail_init_timeout_i;
    hw_set[SB_PARITY] = p_perr;
    hw_set[SB_CKSUM_LSB+:3] = checksum_error_i;
    hw_set[SB_WATCHDOG_TWO] = watchdog_two_error_i;
    hw_set[SB_WATCHDOG_ONE] = watchdog_one_error_i;
    hw_set[SB_STATE_CHG] = r_d.state != r_q.state;
    hw_set[SB_BRIGHT] = over_bright_i;
    hw_set[SB_RAIL_FAULT] = |fault_raw[FLT_RAIL_MSB:FLT_RAIL_LSB];
    hw_set[SB_TEMP_WARN] = temp_warn;
    hw_set[SB_TEMP_ERR] = temp_err;
    if (p_wr && p_wr_addr == REG_STATUS_CLEAR) begin
      r_d.sticky = r_q.sticky & ~p_wr_data;
    end
    if (p_wr && p_wr_addr == REG_STATUS_SET) begin
      r_d.sticky = r_q.sticky | p_wr_data;
    end
    r_d.sticky = r_d.sticky | hw_set;
    if (p_wr && p_wr_addr == REG_CONV_CLEAR) begin
      r_d.conv = r_q.conv & ~p_wr_data[CONV_W-1:0];
    end
    if (p_wr && p_wr_addr == REG_CONV_STATUS) begin
      r_d.conv = r_q.conv | p_wr_data[CONV_W-1:0];
    end
    r_d.conv = r_d.conv | converter_error_i;
    r_d.fault = fault_raw & FAULT_USED_MASK;

    // The ratio is refreshed once per window; very fast clocks saturate.
    r_d.win = r_q.win + 4'h1;
    if (r_q.win == RATIO_WINDOW_LAST) begin
      r_d.snap = seq_bin;
      r_d.ratio = (ratio_scaled > 10'(RATIO_MAX)) ? RATIO_MAX : ratio_scaled[3:0];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r_q <= '{state: s_off, cause: CAUSE_POWER_ON, park_n: 1'b1, activity: 1'b1,
               sticky: STATUS_RESET, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  assign mirror_park_n_o = r_q.park_n;
  assign supplies_enable_o = r_q.supplies;
  assign mirror_regulator_enable_o = r_q.regulators;
  assign activity_enable_o = r_q.activity;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence enter_shutdown;
    r_q.state != s_shutdown ##1 r_q.state == s_shutdown;
  endsequence
  sequence park_timer_done;
    r_q.state == s_park_count && r_q.timer == 8'h00;
  endsequence

  a_park_output_low: assert property ((r_q.state == s_park_count ||
      r_q.state == s_park_discharge) |-> !mirror_park_n_o) else $error("park low");
  a_park_regs_off: assert property (park_timer_done |=> r_q.state == s_park_discharge &&
      !mirror_regulator_enable_o) else $error("park discharge");
  a_shutdown_cause: assert property (enter_shutdown |-> $past(temp_err))
      else $error("shutdown cause");
  a_shutdown_supplies: assert property (r_q.state == s_shutdown |->
      !supplies_enable_o && !activity_enable_o) else $error("shutdown off");
  a_shutdown_hold: assert property (r_q.state == s_shutdown && sys_on |=>
      r_q.state == s_shutdown) else $error("shutdown exit");
  a_status_w1s: assert property (p_wr && p_wr_addr == REG_STATUS_SET |=>
      (r_q.sticky & $past(p_wr_data)) == $past(p_wr_data)) else $error("w1s");
  a_fault_summary: assert property (any_fault |-> status_rd[SB_ANY_FAULT])
      else $error("fault summary");
  a_parity_flag: assert property (p_perr |=> r_q.sticky[SB_PARITY])
      else $error("parity flag");
  a_conv_summary: assert property ((|r_q.conv) |-> status_rd[SB_CONV])
      else $error("converter summary");
  a_state_change: assert property (r_q.state != $past(r_q.state) |-> r_q.sticky[SB_STATE_CHG])
      else $error("state change flag");
  a_sys_off_bit: assert property (!sys_on |-> status_rd[SB_SYS_OFF])
      else $error("system off bit");
endmodule // system_status_fault_regs

`default_nettype wire

// >>> serial_host_model.sv
// Serial register host model that plays the display controller on one port.
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  input wire logic clk_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  // Idle levels follow the board pull-downs on clock and data; select rests high.
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // One whole frame; sck runs at clk/8 so the pin synchroniser never drops an edge.
  task automatic xfer(input logic wr, input logic [6:0] a, input logic [15:0] d,
                      input logic bad, output logic [15:0] q);
    logic [24:0] f;
    f = {wr, a, d, 1'b0};
    f[0] = ~(^f[24:1]) ^ bad;
    q = 16'h0000;
    cs_n_o <= 1'b0;
    for (int i = 24; i >= 0; i--) begin
      mosi_o <= f[i];
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      if (i >= 1 && i <= 16) q[i-1] = miso_i;
      repeat (2) @(posedge clk_i);
      sck_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    mosi_o <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
endmodule // serial_host_model
`default_nettype wire

// >>> system_status_fault_regs_tb.sv
// Self-checking bench for the status and fault register block.
`timescale 1ns/1ps
`default_nettype none
module system_status_fault_regs_tb;
  import status_fault_pkg::*;
  logic clk_i = 1'b0, arst_n_i = 1'b0, sequencer_clock_i = 1'b0, system_on_request_i = 1'b0;
  logic die_temp_warn_i = 1'b0, die_temp_error_i = 1'b0, display_request_i = 1'b0;
  logic park_request_i = 1'b0, power_cycle_request_i = 1'b0, watchdog_one_error_i = 1'b0;
  logic watchdog_two_error_i = 1'b0, pulse_width_limit_i = 1'b0, rail_init_timeout_i = 1'b0;
  logic over_bright_i = 1'b0;
  logic [2:0] checksum_error_i = 3'h0;
  logic [7:0] converter_error_i = 8'h00;
  logic [15:0] supply_fault_i = 16'h0000;
  logic [15:0] q;
  logic p1_sck, p1_cs_n, p1_mosi, p1_miso, p2_sck, p2_cs_n, p2_mosi, p2_miso;
  logic mirror_park_n_o, supplies_enable_o, mirror_regulator_enable_o, activity_enable_o;
  int failures = 0, tests_run = 0, cycles = 0;
  // Core clock, and a link clock with its own period and an odd start offset.
  always #25 clk_i = ~clk_i;
  initial begin
    #7;
    forever #32 sequencer_clock_i = ~sequencer_clock_i;
  end
  system_status_fault_regs dut_u (.clk_i, .arst_n_i, .sequencer_clock_i, .system_on_request_i,
    .die_temp_warn_i, .die_temp_error_i, .supply_fault_i, .display_request_i, .park_request_i,
    .power_cycle_request_i, .watchdog_one_error_i, .watchdog_two_error_i, .pulse_width_limit_i,
    .rail_init_timeout_i, .checksum_error_i, .over_bright_i, .converter_error_i,
    .primary_serial_port_sck_i(p1_sck), .primary_serial_port_cs_n_i(p1_cs_n),
    .primary_serial_port_mosi_i(p1_mosi), .primary_serial_port_miso_o(p1_miso),
    .secondary_serial_port_sck_i(p2_sck), .secondary_serial_port_cs_n_i(p2_cs_n),
    .secondary_serial_port_mosi_i(p2_mosi), .secondary_serial_port_miso_o(p2_miso),
    .mirror_park_n_o, .supplies_enable_o, .mirror_regulator_enable_o, .activity_enable_o);
  serial_host_model h1_u (.clk_i, .sck_o(p1_sck), .cs_n_o(p1_cs_n), .mosi_o(p1_mosi),
    .miso_i(p1_miso));
  serial_host_model h2_u (.clk_i, .sck_o(p2_sck), .cs_n_o(p2_cs_n), .mosi_o(p2_mosi),
    .miso_i(p2_miso));
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report;
    if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Read through either port and keep only the bits of interest.
  task automatic rd(input bit sec, input logic [6:0] a, input logic [15:0] m);
    if (sec) h2_u.xfer(1'b0, a, 16'h0000, 1'b0, q);
    else h1_u.xfer(1'b0, a, 16'h0000, 1'b0, q);
    q = q & m;
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic bad);
    h1_u.xfer(1'b1, a, d, bad, q);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Pulse the checksum, bright, pulse-width, rail-init, watchdog and temperature warning sources together, then set bit 15 by a write.
  task automatic t_sticky;
    rd(0, REG_GENERAL_ONE, 16'h00FF);
    chk("gs", q, {8'h00, CAUSE_POWER_ON, TOP_OFF});
    {checksum_error_i, over_bright_i, pulse_width_limit_i, rail_init_timeout_i} <= 6'h3F;
    {watchdog_one_error_i, watchdog_two_error_i, die_temp_warn_i} <= 3'h7;
    cyc(4);
    {checksum_error_i, over_bright_i, pulse_width_limit_i, rail_init_timeout_i} <= 6'h00;
    {watchdog_one_error_i, watchdog_two_error_i, die_temp_warn_i} <= 3'h0;
    cyc(4);
    wr(REG_STATUS_SET, 16'h0000, 1'b0);
    wr(REG_STATUS_SET, 16'h8000, 1'b0);
    rd(0, REG_STATUS_SET, 16'hFFFF);
    chk("st", q, 16'hE7D5);
    wr(REG_STATUS_CLEAR, 16'hFFFF, 1'b0);
  endtask
  // Converter flags by event and by write, a bad-parity write, a supply fault.
  task automatic t_conv_fault;
    converter_error_i <= 8'h08;
    cyc(1);
    converter_error_i <= 8'h00;
    wr(REG_CONV_STATUS, 16'h0080, 1'b0);
    rd(0, REG_CONV_STATUS, 16'hFFFF);
    chk("cv", q, 16'h0088);
    rd(1, REG_STATUS_SET, 16'h0800);
    chk("cvor", q, 16'h0800);
    wr(REG_CONV_CLEAR, 16'h00FF, 1'b0);
    wr(REG_STATUS_CLEAR, 16'hFFFF, 1'b0);
    wr(REG_STATUS_SET, 16'h0040, 1'b1);
    h2_u.xfer(1'b1, REG_STATUS_SET, 16'h0020, 1'b0, q);
    rd(0, REG_STATUS_SET, 16'hFFFF);
    chk("par", q, 16'h1001);
    supply_fault_i <= 16'h2000;
    cyc(4);
    rd(1, REG_SUPPLY_FAULT, 16'hFFFF);
    chk("flt", q, 16'h2000);
    rd(1, REG_STATUS_SET, 16'h8008);
    chk("anyf", q, 16'h8008);
    supply_fault_i <= 16'h0000;
    cyc(4);
    wr(REG_STATUS_CLEAR, 16'hFFFF, 1'b0);
  endtask
  // Power up, show, park back to standby, then over-temperature shutdown.
  task automatic t_states;
    system_on_request_i <= 1'b1;
    cyc(8);
    rd(0, REG_STATUS_SET, 16'h0020);
    chk("chg", q, 16'h0020);
    display_request_i <= 1'b1;
    cyc(2);
    display_request_i <= 1'b0;
    cyc(4);
    // A 64 ns link clock gives 12 or 13 edges per 16-cycle window, which scales to 4.
    rd(0, REG_GENERAL_ONE, 16'hF01F);
    chk("disp", q, {4'h4, 7'h00, TOP_DISPLAY});
    park_request_i <= 1'b1;
    cyc(2);
    park_request_i <= 1'b0;
    cyc(4);
    #1;
    chk("park", {14'h0000, mirror_park_n_o, mirror_regulator_enable_o}, 16'h0001);
    chk("on", {14'h0000, supplies_enable_o, activity_enable_o}, 16'h0003);
    cyc(44);
    #1;
    chk("dc", {14'h0000, mirror_park_n_o, mirror_regulator_enable_o}, 16'h0000);
    cyc(40);
    rd(0, REG_GENERAL_ONE, 16'h001F);
    chk("stby", q | {15'h0000, ~mirror_park_n_o}, {11'h000, TOP_STANDBY});
    die_temp_error_i <= 1'b1;
    cyc(8);
    #1;
    chk("halt", {14'h0000, supplies_enable_o, activity_enable_o}, 16'h0000);
    cyc(1);
    die_temp_error_i <= 1'b0;
    rd(1, REG_GENERAL_ONE, 16'h001F);
    chk("shut", q, {11'h000, TOP_SHUTDOWN});
    system_on_request_i <= 1'b0;
    cyc(8);
    rd(1, REG_GENERAL_ONE, 16'h00FF);
    chk("cause", q, {8'h00, CAUSE_OVER_TEMP, TOP_OFF});
  endtask
  // Hang guard well above the few thousand cycles the sequence needs.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      final_report();
    end
  end
  // Main sequence.
  initial begin
    cyc(16);
    arst_n_i <= 1'b1;
    cyc(2);
    t_sticky();
    t_conv_fault();
    t_states();
    final_report();
  end
endmodule // system_status_fault_regs_tb
`default_nettype wire
